// *** sso_defines.vh ***
// register offsets, field positions, reset values and constants of the section overhead register bank
`ifndef SSO_DEFINES_VH
`define SSO_DEFINES_VH

// ======================================================================
// register offsets on the 8-bit processor bus
`define SSO_ADDR_MASTER     8'h00
`define SSO_ADDR_RX_CTRL    8'h10
`define SSO_ADDR_RX_STAT    8'h11
`define SSO_ADDR_CNT_LO     8'h12
`define SSO_ADDR_CNT_HI     8'h13
`define SSO_ADDR_TX_CTRL    8'h14

// ======================================================================
// receive control field positions
`define SSO_RXC_SCR_OFF     6
`define SSO_RXC_FRC_MISFR   5
`define SSO_RXC_B1_IEN      3
`define SSO_RXC_LOS_IEN     2
`define SSO_RXC_LOF_IEN     1
`define SSO_RXC_OOF_IEN     0

// ======================================================================
// receive status field positions
`define SSO_RXS_C1_FLAG     7
`define SSO_RXS_B1_FLAG     6
`define SSO_RXS_LOS_FLAG    5
`define SSO_RXS_LOF_FLAG    4
`define SSO_RXS_OOF_FLAG    3
`define SSO_RXS_LOS         2
`define SSO_RXS_LOF         1
`define SSO_RXS_OOF         0

// ======================================================================
// transmit control field positions
`define SSO_TXC_SCR_OFF     6
`define SSO_TXC_LAI_INS     0

// ======================================================================
// reset values and datapath constants
`define SSO_RXC_RESET       8'h00
`define SSO_TXC_RESET       8'h00
`define SSO_STAT_RESET      8'h00
`define SSO_CNT_RESET       16'h0000
`define SSO_CNT_MAX         16'hffff
`define SSO_SCR_SEED        7'h7f
`define SSO_LAI_BYTE        8'hff

`endif

// *** sso_err_cnt.v ***
// section parity error accumulator with poll-to-holding transfer
module sso_err_cnt (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        err_inc,
	input  wire        poll,
	output reg  [15:0] hold_ff
);
`include "sso_defines.vh"

	reg  [15:0] acc_ff;
	reg  [15:0] nxt_acc;
	reg  [15:0] nxt_hold;
	wire [15:0] acc_plus;

	// saturate rather than wrap so a long unpolled interval never reads small
	assign acc_plus = (acc_ff == `SSO_CNT_MAX) ? acc_ff : acc_ff + 16'h0001;

	// a poll moves the running total, including a coincident error, into the holder
	always @* begin
		nxt_acc  = acc_ff;
		nxt_hold = hold_ff;
		if (poll) begin
			nxt_hold = err_inc ? acc_plus : acc_ff;
			nxt_acc  = `SSO_CNT_RESET;
		end else if (err_inc) begin
			nxt_acc  = acc_plus;
		end
	end

	// accumulator and holding register
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			acc_ff  <= `SSO_CNT_RESET;
			hold_ff <= `SSO_CNT_RESET;
		end else begin
			acc_ff  <= nxt_acc;
			hold_ff <= nxt_hold;
		end
	end

endmodule

// *** sso_regs.v ***
// section overhead control/status register bank with rx descrambler and tx alarm/scrambler stage
//
// Contract
// - descrambler off bit bypasses rx descrambling
// - force misframe acts at next frame boundary
// - parity error interrupt when its enable set
// - alarm change interrupts under separate enables
// - trace byte mismatch flag, cleared on read
// - parity event flag, cleared on status read
// - alarm change flags, cleared on status read
// - status shows live alarms in low bits
// - sixteen-bit count read as two bytes
// - counter byte write polls into holding register
// - error coincident with poll is kept
// - master address write polls all counters
// - tx scrambler off bit disables scrambling
// - line alarm forces non-overhead bits to one ahead of the tx scrambler
module sso_regs (
	input  wire       core_clk,
	input  wire       rst,
	input  wire [7:0] proc_addr,
	input  wire [7:0] proc_wdata,
	input  wire       proc_wr,
	input  wire       proc_rd,
	output reg  [7:0] proc_rdata_ff,
	output reg        irq_ff,
	output reg        master_poll_ff,
	input  wire       signal_missing_alarm,
	input  wire       frame_missing_alarm,
	input  wire       misframe_alarm,
	input  wire       b1_error,
	input  wire       c1_mismatch,
	input  wire       rx_frame_boundary,
	output reg        force_misframe_ff,
	input  wire [7:0] rx_byte,
	input  wire       rx_byte_vld,
	input  wire       rx_byte_hdr,
	output reg  [7:0] rx_clear_byte_ff,
	output reg        rx_clear_vld_ff,
	input  wire [7:0] tx_byte,
	input  wire       tx_byte_vld,
	input  wire       tx_byte_soh,
	input  wire       tx_byte_hdr,
	output reg  [7:0] tx_line_byte_ff,
	output reg        tx_line_vld_ff
);
`include "sso_defines.vh"

	// ======================================================================
	// frame synchronous scrambler step, x^7 + x^6 + 1, msb first
	function [14:0] sso_scr_step;
		input [6:0] st;
		input [7:0] din;
		reg   [6:0] s;
		reg   [7:0] o;
		integer     i;
		begin
			s = st;
			o = 8'h00;
			for (i = 7; i >= 0; i = i - 1) begin
				o[i] = din[i] ^ s[6];
				s    = {s[5:0], s[6] ^ s[5]};
			end
			sso_scr_step = {s, o};
		end
	endfunction

	// ======================================================================
	// register state
	reg         rx_scr_off_ff;
	reg         b1_ien_ff;
	reg         los_ien_ff;
	reg         lof_ien_ff;
	reg         oof_ien_ff;
	reg         misframe_pend_ff;
	reg         tx_scr_off_ff;
	reg         lai_ins_ff;
	reg         c1_flag_ff;
	reg         b1_flag_ff;
	reg         los_flag_ff;
	reg         lof_flag_ff;
	reg         oof_flag_ff;
	reg         los_prev_ff;
	reg         lof_prev_ff;
	reg         oof_prev_ff;
	reg   [6:0] rx_scr_ff;
	reg   [6:0] tx_scr_ff;

	wire        wr_rxc;
	wire        wr_txc;
	wire        rd_stat;
	wire        poll;
	wire        los_chg;
	wire        lof_chg;
	wire        oof_chg;
	wire [15:0] cnt_hold;
	wire [14:0] rx_step;
	wire [14:0] tx_step;
	wire  [7:0] tx_masked;
	wire  [7:0] stat_val;
	reg   [7:0] rd_mux;

	// ======================================================================
	// address decode; the bus is taken as synchronous to core_clk
	assign wr_rxc  = proc_wr & (proc_addr == `SSO_ADDR_RX_CTRL);
	assign wr_txc  = proc_wr & (proc_addr == `SSO_ADDR_TX_CTRL);
	assign rd_stat = proc_rd & (proc_addr == `SSO_ADDR_RX_STAT);
	assign poll    = proc_wr & ((proc_addr == `SSO_ADDR_CNT_LO) |
	                            (proc_addr == `SSO_ADDR_CNT_HI) |
	                            (proc_addr == `SSO_ADDR_MASTER));

	// ======================================================================
	// control registers
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_scr_off_ff <= 1'b0;
			b1_ien_ff     <= 1'b0;
			los_ien_ff    <= 1'b0;
			lof_ien_ff    <= 1'b0;
			oof_ien_ff    <= 1'b0;
			tx_scr_off_ff <= 1'b0;
			lai_ins_ff    <= 1'b0;
		end else begin
			if (wr_rxc) begin
				rx_scr_off_ff <= proc_wdata[`SSO_RXC_SCR_OFF];
				b1_ien_ff     <= proc_wdata[`SSO_RXC_B1_IEN];
				los_ien_ff    <= proc_wdata[`SSO_RXC_LOS_IEN];
				lof_ien_ff    <= proc_wdata[`SSO_RXC_LOF_IEN];
				oof_ien_ff    <= proc_wdata[`SSO_RXC_OOF_IEN];
			end
			if (wr_txc) begin
				tx_scr_off_ff <= proc_wdata[`SSO_TXC_SCR_OFF];
				lai_ins_ff    <= proc_wdata[`SSO_TXC_LAI_INS];
			end
		end
	end

	// ======================================================================
	// force misframe: held pending until the framer reaches a frame boundary
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			misframe_pend_ff  <= 1'b0;
			force_misframe_ff <= 1'b0;
		end else begin
			// a new request in the boundary cycle stays pending for the next one
			misframe_pend_ff  <= (wr_rxc & proc_wdata[`SSO_RXC_FRC_MISFR]) |
			                     (misframe_pend_ff & ~rx_frame_boundary);
			force_misframe_ff <= misframe_pend_ff & rx_frame_boundary;
		end
	end

	// ======================================================================
	// alarm change detection and sticky event flags; a set beats a read-clear
	assign los_chg = signal_missing_alarm ^ los_prev_ff;
	assign lof_chg = frame_missing_alarm ^ lof_prev_ff;
	assign oof_chg = misframe_alarm ^ oof_prev_ff;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			los_prev_ff <= 1'b0;
			lof_prev_ff <= 1'b0;
			oof_prev_ff <= 1'b0;
			c1_flag_ff  <= 1'b0;
			b1_flag_ff  <= 1'b0;
			los_flag_ff <= 1'b0;
			lof_flag_ff <= 1'b0;
			oof_flag_ff <= 1'b0;
		end else begin
			los_prev_ff <= signal_missing_alarm;
			lof_prev_ff <= frame_missing_alarm;
			oof_prev_ff <= misframe_alarm;
			c1_flag_ff  <= c1_mismatch | (c1_flag_ff & ~rd_stat);
			b1_flag_ff  <= b1_error | (b1_flag_ff & ~rd_stat);
			los_flag_ff <= los_chg | (los_flag_ff & ~rd_stat);
			lof_flag_ff <= lof_chg | (lof_flag_ff & ~rd_stat);
			oof_flag_ff <= oof_chg | (oof_flag_ff & ~rd_stat);
		end
	end

	// ======================================================================
	// interrupt: the trace byte flag has no enable and so never drives it
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (b1_flag_ff & b1_ien_ff) |
			          (los_flag_ff & los_ien_ff) |
			          (lof_flag_ff & lof_ien_ff) |
			          (oof_flag_ff & oof_ien_ff);
		end
	end

	// ======================================================================
	// parity error counter with poll
	sso_err_cnt u_b1_cnt (
		.core_clk (core_clk),
		.rst      (rst),
		.err_inc  (b1_error),
		.poll     (poll),
		.hold_ff  (cnt_hold)
	);

	// other receive counters follow this pulse one cycle after a master write
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			master_poll_ff <= 1'b0;
		end else begin
			master_poll_ff <= proc_wr & (proc_addr == `SSO_ADDR_MASTER);
		end
	end

	// ======================================================================
	// read path
	assign stat_val = {c1_flag_ff, b1_flag_ff, los_flag_ff, lof_flag_ff, oof_flag_ff,
	                   signal_missing_alarm, frame_missing_alarm, misframe_alarm};

	always @* begin
		rd_mux = 8'h00;
		case (proc_addr)
			`SSO_ADDR_RX_CTRL: begin
				// force misframe is write-only and reads zero
				rd_mux[`SSO_RXC_SCR_OFF] = rx_scr_off_ff;
				rd_mux[`SSO_RXC_B1_IEN]  = b1_ien_ff;
				rd_mux[`SSO_RXC_LOS_IEN] = los_ien_ff;
				rd_mux[`SSO_RXC_LOF_IEN] = lof_ien_ff;
				rd_mux[`SSO_RXC_OOF_IEN] = oof_ien_ff;
			end
			`SSO_ADDR_RX_STAT: begin
				rd_mux = stat_val;
			end
			`SSO_ADDR_CNT_LO: begin
				rd_mux = cnt_hold[7:0];
			end
			`SSO_ADDR_CNT_HI: begin
				rd_mux = cnt_hold[15:8];
			end
			`SSO_ADDR_TX_CTRL: begin
				rd_mux[`SSO_TXC_SCR_OFF] = tx_scr_off_ff;
				rd_mux[`SSO_TXC_LAI_INS] = lai_ins_ff;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// read data holds its last value between reads
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			proc_rdata_ff <= 8'h00;
		end else if (proc_rd) begin
			proc_rdata_ff <= rd_mux;
		end
	end

	// ======================================================================
	// receive descrambler; header bytes pass clear and hold the seed
	assign rx_step = sso_scr_step(rx_scr_ff, rx_byte);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_scr_ff        <= `SSO_SCR_SEED;
			rx_clear_byte_ff <= 8'h00;
			rx_clear_vld_ff  <= 1'b0;
		end else begin
			rx_clear_vld_ff <= rx_byte_vld;
			if (rx_byte_vld) begin
				if (rx_byte_hdr) begin
					rx_scr_ff        <= `SSO_SCR_SEED;
					rx_clear_byte_ff <= rx_byte;
				end else if (rx_scr_off_ff) begin
					rx_clear_byte_ff <= rx_byte;
				end else begin
					rx_scr_ff        <= rx_step[14:8];
					rx_clear_byte_ff <= rx_step[7:0];
				end
			end
		end
	end

	// ======================================================================
	// transmit stage: line alarm applied first, then the scrambler
	assign tx_masked = (lai_ins_ff & ~tx_byte_soh) ? `SSO_LAI_BYTE : tx_byte;
	assign tx_step   = sso_scr_step(tx_scr_ff, tx_masked);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_scr_ff       <= `SSO_SCR_SEED;
			tx_line_byte_ff <= 8'h00;
			tx_line_vld_ff  <= 1'b0;
		end else begin
			tx_line_vld_ff <= tx_byte_vld;
			if (tx_byte_vld) begin
				if (tx_byte_hdr) begin
					tx_scr_ff       <= `SSO_SCR_SEED;
					tx_line_byte_ff <= tx_masked;
				end else if (tx_scr_off_ff) begin
					tx_line_byte_ff <= tx_masked;
				end else begin
					tx_scr_ff       <= tx_step[14:8];
					tx_line_byte_ff <= tx_step[7:0];
				end
			end
		end
	end

endmodule

// *** sso_regs_asserts.sv ***
// concurrent checks on the section overhead register bank ports
`include "sso_defines.vh"
module sso_regs_asserts (
	input wire       core_clk,
	input wire       rst,
	input wire [7:0] proc_addr,
	input wire       proc_wr,
	input wire       proc_rd,
	input wire [7:0] proc_rdata_ff,
	input wire       master_poll_ff,
	input wire       force_misframe_ff,
	input wire       rx_frame_boundary,
	input wire       signal_missing_alarm,
	input wire       frame_missing_alarm,
	input wire       misframe_alarm,
	input wire [7:0] rx_byte,
	input wire       rx_byte_vld,
	input wire       rx_byte_hdr,
	input wire [7:0] rx_clear_byte_ff,
	input wire       rx_clear_vld_ff
);
	// ======================================================================
	// one clock domain, so clock and reset are stated once
	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (rst);
	// read answers, one cycle after the strobe
	a_unmapped_reads_zero: assert property (proc_rd && proc_addr == 8'h20 |=> proc_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	a_frc_reads_zero: assert property (proc_rd && proc_addr == 8'h10 |=> !proc_rdata_ff[5])
		else $error("force misframe bit read back");
	a_live_alarm_bits: assert property (proc_rd && proc_addr == 8'h11 |=>
		proc_rdata_ff[2:0] == {$past(signal_missing_alarm), $past(frame_missing_alarm), $past(misframe_alarm)})
		else $error("status alarm bits wrong");
	// poll fan-out to the other counters
	// a second master write right behind the first legally keeps the pulse up
	a_master_poll_pulse: assert property (proc_wr && proc_addr == 8'h00 |=> master_poll_ff ##1
		(master_poll_ff == ($past(proc_wr) && $past(proc_addr) == 8'h00)))
		else $error("master poll pulse missing");
	a_master_poll_cause: assert property (master_poll_ff |-> $past(proc_wr) && $past(proc_addr) == 8'h00)
		else $error("master poll without write");
	// misframe request only lands on a frame boundary, as a single pulse
	a_misframe_boundary: assert property (force_misframe_ff |-> $past(rx_frame_boundary))
		else $error("misframe pulse off boundary");
	a_misframe_single: assert property ($rose(force_misframe_ff) |=> !force_misframe_ff)
		else $error("misframe pulse too long");
	// receive byte path keeps a fixed latency and header bytes untouched
	a_rx_byte_latency: assert property (rx_byte_vld |=> rx_clear_vld_ff)
		else $error("descrambled byte late");
	a_rx_hdr_pass: assert property (rx_byte_vld && rx_byte_hdr |=> rx_clear_byte_ff == $past(rx_byte))
		else $error("header byte altered");
endmodule
bind sso_regs sso_regs_asserts u_chk (.*);

// *** tb_sonet_section_overhead_regs.sv ***
// self-checking bench for the section overhead register bank
`include "sso_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb_sonet_section_overhead_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic       core_clk = 0, rst = 1, proc_wr = 0, proc_rd = 0, b1_error = 0, c1 = 0, bnd = 0;
	logic       sig_miss = 0, frm_miss = 0, misfr = 0, rxv = 0, rxh = 0, txv = 0, txs = 0, txh = 0;
	logic [7:0] proc_addr = 0, proc_wdata = 0, rxb = 0, txb = 0;
	logic [6:0] sv;
	wire  [7:0] rdata, rxo, txo;
	wire        irq, frc, rxvo, txvo;
	int         num_errors = 0, checks = 0, cyc = 0;
	sso_regs dut_u (.core_clk(core_clk), .rst(rst), .proc_addr(proc_addr), .proc_wdata(proc_wdata),
		.proc_wr(proc_wr), .proc_rd(proc_rd), .proc_rdata_ff(rdata), .irq_ff(irq), .master_poll_ff(),
		.signal_missing_alarm(sig_miss), .frame_missing_alarm(frm_miss), .misframe_alarm(misfr),
		.b1_error(b1_error), .c1_mismatch(c1), .rx_frame_boundary(bnd), .force_misframe_ff(frc),
		.rx_byte(rxb), .rx_byte_vld(rxv), .rx_byte_hdr(rxh), .rx_clear_byte_ff(rxo), .rx_clear_vld_ff(rxvo),
		.tx_byte(txb), .tx_byte_vld(txv), .tx_byte_soh(txs), .tx_byte_hdr(txh), .tx_line_byte_ff(txo),
		.tx_line_vld_ff(txvo));
	// ======================================================================
	// clock, hang guard and verdict
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude;
		end
	end
	task conclude;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ======================================================================
	// drivers: inputs move 1 ns after the edge so the design never races them
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		proc_addr = a;
		proc_wdata = d;
		proc_wr = 1;
		tick;
		proc_wr = 0;
		// one idle edge so the next strobe is never raised in the step it was lowered
		tick;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		proc_addr = a;
		proc_rd = 1;
		tick;
		proc_rd = 0;
		`CHK("read data", e, rdata)
		tick;
	endtask
	// bench's own x^7+x^6+1 reference, msb first
	function logic [7:0] scr(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			scr[i] = d[i] ^ sv[6];
			sv = {sv[5:0], sv[6] ^ sv[5]};
		end
	endfunction
	task snd(input logic tx, input logic [7:0] d, input logic h, input logic s, input logic [7:0] e);
		{txb, txh, txs, txv} = {d, h, s, tx};
		{rxb, rxh, rxv} = {d, h, !tx};
		tick;
		txv = 0;
		rxv = 0;
		`CHK("line byte", e, tx ? txo : rxo)
		`CHK("line valid", 1'b1, tx ? txvo : rxvo)
		tick;
	endtask
	// ======================================================================
	// scenarios
	task t_regs;
		for (int i = 0; i < 6; i++) rdc((i == 5) ? 8'h20 : 8'h10 + i[7:0], 8'h00);
		// force misframe written as one here, so the read-back really tests it
		wr(8'h10, 8'hff);
		rdc(8'h10, 8'h4f);
		wr(8'h14, 8'hff);
		rdc(8'h14, 8'h41);
		wr(8'h20, 8'hff);
		rdc(8'h20, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h00);
	endtask
	task t_count;
		wr(8'h10, 8'h08);
		b1_error = 1;
		repeat (3) tick;
		wr(8'h12, 8'h00);
		b1_error = 0;
		rdc(8'h12, 8'h04);
		rdc(8'h13, 8'h00);
		`CHK("irq", 1'b1, irq)
		rdc(8'h11, 8'h40);
		tick;
		`CHK("irq", 1'b0, irq)
		b1_error = 1;
		repeat (300) tick;
		b1_error = 0;
		wr(8'h13, 8'h00);
		// the idle edge after the first poll still counted one error: 1 + 300
		rdc(8'h12, 8'h2d);
		rdc(8'h13, 8'h01);
		wr(8'h00, 8'h00);
		rdc(8'h12, 8'h00);
		rdc(8'h11, 8'h40);
		wr(8'h10, 8'h00);
	endtask
	task t_alarm;
		wr(8'h10, 8'h07);
		sig_miss = 1;
		repeat (3) tick;
		`CHK("irq", 1'b1, irq)
		rdc(8'h11, 8'h24);
		rdc(8'h11, 8'h04);
		`CHK("irq", 1'b0, irq)
		{sig_miss, frm_miss, misfr} = 3'b011;
		repeat (3) tick;
		rdc(8'h11, 8'h3b);
		{frm_miss, misfr} = 2'b00;
		repeat (2) tick;
		rdc(8'h11, 8'h18);
		wr(8'h10, 8'h00);
		c1 = 1;
		tick;
		c1 = 0;
		tick;
		rdc(8'h11, 8'h80);
		`CHK("irq", 1'b0, irq)
	endtask
	task t_frc;
		wr(8'h10, 8'h20);
		repeat (3) begin
			`CHK("misframe", 1'b0, frc)
			tick;
		end
		bnd = 1;
		tick;
		bnd = 0;
		`CHK("misframe", 1'b1, frc)
		tick;
		`CHK("misframe", 1'b0, frc)
	endtask
	task t_data;
		sv = 7'h7f;
		snd(0, 8'h47, 1, 1, 8'h47);
		snd(0, 8'h00, 0, 0, scr(8'h00));
		snd(0, 8'h3c, 0, 0, scr(8'h3c));
		wr(8'h10, 8'h40);
		snd(0, 8'h5a, 0, 0, 8'h5a);
		sv = 7'h7f;
		snd(1, 8'h47, 1, 1, 8'h47);
		snd(1, 8'h00, 0, 0, scr(8'h00));
		wr(8'h14, 8'h01);
		snd(1, 8'h12, 0, 1, scr(8'h12));
		snd(1, 8'h12, 0, 0, scr(8'hff));
		wr(8'h14, 8'h41);
		snd(1, 8'h12, 0, 0, 8'hff);
	endtask
	// ======================================================================
	// reset for ten cycles, then run everything in order
	initial begin
		repeat (10) @(posedge core_clk);
		#1 rst = 0;
		t_regs;
		t_count;
		t_alarm;
		t_frc;
		t_data;
		conclude;
	end
endmodule
